// ===== verification/lbf_rx_model.sv
// partner: scrambler stand-in and stalling serializer with header watch
`default_nettype none
module lbf_rx_model #(
  parameter logic [63:0] MASK = 64'h5a3c96e10f2db487
) (
  input wire logic i_sys_clk, // clock
  input wire logic i_hold, // stall request
  input wire logic [31:0] i_rnd, // random source
  input wire logic [63:0] i_payload, // packed payload
  input wire logic i_blk_valid, // block offered
  input wire logic [65:0] i_block, // offered block
  output logic [63:0] o_scr, // scrambled word, zero latency
  output var logic o_ready, // block accept
  output var logic [7:0] o_bad // bad headers seen
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_scr = i_payload ^ MASK;
  initial begin
    o_ready = 1'b0;
    o_bad = 8'h00;
  end
  always @(posedge i_sys_clk) begin
    o_ready <= !i_hold && (i_rnd[0] || i_rnd[1]);
    if (i_blk_valid && o_ready && i_block[0] == i_block[1]) begin
      o_bad <= o_bad + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// testbench: framer against a queue model of blocks and crc stream
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] MASK = 64'h5a3c96e10f2db487;
  logic i_sys_clk, i_rst, i_sysref, i_oct_valid, i_hold, i_blk_ready, ok;
  logic o_oct_ready, o_pay_valid, o_blk_valid, o_emb, o_mb_start;
  logic [7:0] i_octet, bad;
  logic [63:0] i_scr_payload, o_payload, word;
  logic [65:0] o_block;
  logic [31:0] rnd;
  logic [11:0] crc, prev;
  logic [66:0] expq[$];
  int mismatches, checks, nblk, noct, cyc, npul, n;
  lbf_framer dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sysref(i_sysref),
    .i_oct_valid(i_oct_valid), .o_oct_ready(o_oct_ready), .i_octet(i_octet),
    .i_scr_payload(i_scr_payload), .o_pay_valid(o_pay_valid), .o_payload(o_payload),
    .o_blk_valid(o_blk_valid), .i_blk_ready(i_blk_ready), .o_block(o_block),
    .o_ext_multiblock_timing_clock(o_emb), .o_mb_start(o_mb_start));
  lbf_rx_model #(.MASK(MASK)) rx (.i_sys_clk(i_sys_clk), .i_hold(i_hold), .i_rnd(rnd),
    .i_payload(o_payload), .i_blk_valid(o_blk_valid), .i_block(o_block),
    .o_scr(i_scr_payload), .o_ready(i_blk_ready), .o_bad(bad));
  //////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [66:0] seen, input logic [66:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function logic [31:0] stream(input logic [11:0] c);
    logic [31:0] s;
    s = 32'h80e88888;
    for (int k = 0; k < 12; k++) s[k + k / 3] = c[11 - k];
    return s;
  endfunction
  task model(input logic [7:0] d);
    logic [63:0] scr;
    int b;
    word[8 * (noct % 8) +: 8] = d;
    noct++;
    if (noct % 8 == 0) begin
      scr = word ^ MASK;
      b = nblk % 32;
      expq.push_back({b == 0, scr, stream(prev)[b] ? 2'h2 : 2'h1});
      for (int i = 63; i >= 0; i--) crc = {crc[10:0], 1'b0} ^ ((crc[11] ^ scr[i]) ? 12'h30f : 12'h0);
      nblk++;
      if (b == 31) begin
        prev = crc;
        crc = 12'h000;
      end
    end
  endtask
  task send(output logic acc);
    n = 0;
    i_oct_valid <= 1'b1;
    i_octet <= rnd[15:8];
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_oct_ready !== 1'b1 && n < 40);
    acc = (o_oct_ready === 1'b1);
    if (acc) model(i_octet);
    else i_oct_valid <= 1'b0;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    rnd <= xs(rnd);
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      conclude();
    end
    if (!i_rst && o_emb === 1'b1) npul++;
    if (!i_rst && o_blk_valid === 1'b1 && i_blk_ready) begin
      if (expq.size() == 0) check("extra block", 67'h1, 67'h0);
      else check("block", {o_mb_start, o_block}, expq.pop_front());
    end
  end
  initial begin
    {i_rst, i_sysref, i_oct_valid, i_hold, i_octet, rnd} = {1'b1, 3'h0, 8'h00, 32'h28};
    {mismatches, checks, nblk, noct, cyc, npul, crc, prev} = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk) i_sysref <= 1'b1;
    @(posedge i_sys_clk) i_sysref <= 1'b0;
    @(posedge i_sys_clk) check("sysref pulse", o_emb, 67'h1);
    repeat (512) send(ok);
    i_hold <= 1'b1;
    ok = 1'b1;
    while (ok) send(ok);
    check("full refusal", o_oct_ready, 67'h0);
    i_hold <= 1'b0;
    @(posedge i_sys_clk);
    while (noct % 8 != 0 || nblk < 100) send(ok);
    i_oct_valid <= 1'b0;
    for (n = 0; n < 2000 && expq.size() > 0; n++) @(posedge i_sys_clk);
    repeat (5) @(posedge i_sys_clk);
    check("queue drained", expq.size(), 67'h0);
    check("timing pulses", npul, 1 + nblk / 32);
    check("bad headers", bad, 67'h0);
    conclude();
  end
endmodule
`default_nettype wire

// ===== verilog/lbf_fifo.sv
// file: small valid/ready fifo
`default_nettype none
module lbf_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,            // clock
  input wire logic i_rst,                // sync reset
  input wire logic i_valid,              // write request
  output logic o_ready,                  // not full
  input wire logic [WIDTH-1:0] i_data,   // write data
  output logic o_valid,                  // not empty
  input wire logic i_ready,              // read accept
  output logic [WIDTH-1:0] o_data        // head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lbf_fifo_st_t;
  lbf_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr, rd;
  assign o_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign o_valid = (s_q.cnt != '0);
  assign o_data = mem[s_q.rp];
  assign wr = i_valid && o_ready;
  assign rd = i_ready && o_valid;
  always_comb begin
    s_d = s_q;
    if (wr) s_d.wp = AW'((32'(s_q.wp) + 1) % DEPTH);
    if (rd) s_d.rp = AW'((32'(s_q.rp) + 1) % DEPTH);
    s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) s_q <= '0;
    else s_q <= s_d;
    if (wr) mem[s_q.wp] <= i_data;
  end
endmodule
`default_nettype wire

// ===== verilog/lbf_framer.sv
// file: 64b/66b transmit block framer with multiblock timing and crc-12 stream
//
// Behaviour
// - pack eight octets into 64-bit payload
// - two-bit header then scrambled payload
// - header bits 0-1, octet k at 2+8k
// - 32 blocks form one multiblock
// - only one multiblock per extended multiblock
// - whole frames per extended multiblock
// - sysref resets extended multiblock timing clock
// - timing clock period 66x32xE line bits
// - header always 01 or 10
// - header 01 is one, 10 is zero
// - 32 header bits form stream word
// - stream ends 00001, unique in crc mode
// - stream bit 22 flags extended multiblock end
// - only crc-12 stream mode provided
// - crc over 2048 payload bits, sent next
// - crc bits and fixed ones at mapped positions
// - command positions always zero
// - crc polynomial 0x987
// - crc cleared per multiblock, read after 2048
`default_nettype none
module lbf_framer #(
  parameter int FIFO_DEPTH = lbf_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,                  // 250 mhz clock
  input wire logic i_rst,                      // sync reset, active high
  input wire logic i_sysref,                   // timing reference pulse
  input wire logic i_oct_valid,                // octet in valid
  output logic o_oct_ready,                    // octet in ready
  input wire logic [7:0] i_octet,              // transport octet
  input wire logic [63:0] i_scr_payload,       // scrambled payload back
  output logic o_pay_valid,                    // packed payload to scrambler
  output logic [63:0] o_payload,               // packed payload, payload_octet_zero first
  output logic o_blk_valid,                    // 66-bit block out valid
  input wire logic i_blk_ready,                // block accepted by serializer
  output logic [65:0] o_block,                 // line bit0 first
  output logic o_ext_multiblock_timing_clock,  // pulse at emb boundary
  output logic o_mb_start                      // first block of multiblock
);
  typedef struct packed {
    logic [2:0] oct_cnt;
    logic [63:0] pack;
    logic pay_valid;
    logic [63:0] payload;
    logic [4:0] blk_idx;
    logic [11:0] crc;
    logic [11:0] crc_prev;
    logic [31:0] stream;
    logic blk_valid;
    logic [65:0] block;
    logic emb_clk;
    logic mb_start;
  } lbf_st_t;
  lbf_st_t s_q, s_d;

  logic f_valid, f_ready;
  logic [63:0] f_data;

  ////////////////////////////////////////////////////////////////////////////
  // crc-12 step over one 64-bit word, msb of the last octet (bit 63) first
  function automatic logic [11:0] crc_word(input logic [11:0] c, input logic [63:0] w);
    logic [11:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 64; i++) begin
      fb = r[11] ^ w[63-i];
      r = {r[10:0], 1'b0};
      // hex form drops the +1 term and keeps x^12 as its msb
      if (fb) r = r ^ {lbf_pkg::CRC_POLY[10:0], 1'b1};
    end
    return r;
  endfunction

  // stream word for one multiblock from previous crc
  function automatic logic [31:0] build_stream(input logic [11:0] c);
    logic [31:0] s;
    s = lbf_pkg::FIXED_ONES;
    s[2:0] = {c[9], c[10], c[11]};
    s[6:4] = {c[6], c[7], c[8]};
    s[10:8] = {c[3], c[4], c[5]};
    s[14:12] = {c[0], c[1], c[2]};
    s[lbf_pkg::EMB_END_BIT] = (lbf_pkg::MB_PER_EMB == 1);
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scrambled payloads wait here for block assembly
  lbf_fifo #(.WIDTH(lbf_pkg::PAYLOAD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_valid(s_q.pay_valid),
    .o_ready(f_ready),
    .i_data(i_scr_payload),
    .o_valid(f_valid),
    .i_ready(!s_q.blk_valid || i_blk_ready),
    .o_data(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic take;
    logic [31:0] strm;
    logic [65:0] b;
    logic hb;
    take = 1'b0;
    strm = '0;
    b = '0;
    hb = 1'b0;
    s_d = s_q;
    s_d.emb_clk = 1'b0;
    // packer stalls while its payload register is full and fifo cannot take it
    if (s_q.pay_valid && f_ready) s_d.pay_valid = 1'b0;
    if (i_oct_valid && o_oct_ready) begin
      s_d.pack[8*s_q.oct_cnt +: 8] = i_octet;
      s_d.oct_cnt = s_q.oct_cnt + 3'h1;
      if (s_q.oct_cnt == 3'h7) begin
        s_d.payload = {i_octet, s_q.pack[55:0]};
        s_d.pay_valid = 1'b1;
      end
    end
    if (s_q.blk_valid && i_blk_ready) s_d.blk_valid = 1'b0;
    take = f_valid && (!s_q.blk_valid || i_blk_ready);
    if (take) begin
      strm = (s_q.blk_idx == 5'h0) ? build_stream(s_q.crc_prev) : s_q.stream;
      hb = strm[s_q.blk_idx];
      b[1:0] = hb ? lbf_pkg::HDR_ONE : lbf_pkg::HDR_ZERO;
      for (int k = 0; k < lbf_pkg::OCTETS_PER_BLOCK; k++) begin
        b[2+8*k +: 8] = f_data[8*k +: 8];
      end
      s_d.block = b;
      s_d.blk_valid = 1'b1;
      s_d.stream = strm;
      s_d.mb_start = (s_q.blk_idx == 5'h0);
      s_d.blk_idx = s_q.blk_idx + 5'h1;
      if (s_q.blk_idx == 5'h1f) begin
        s_d.crc_prev = crc_word(s_q.crc, f_data);
        s_d.crc = '0;
        s_d.emb_clk = 1'b1;
      end else begin
        s_d.crc = crc_word(s_q.crc, f_data);
      end
    end
    // sysref realigns the multiblock phase and timing clock
    if (i_sysref) begin
      s_d.blk_idx = '0;
      s_d.crc = '0;
      s_d.emb_clk = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_oct_ready = !s_q.pay_valid || f_ready;
  assign o_pay_valid = s_q.pay_valid;
  assign o_payload = s_q.payload;
  assign o_blk_valid = s_q.blk_valid;
  assign o_block = s_q.block;
  assign o_ext_multiblock_timing_clock = s_q.emb_clk;
  assign o_mb_start = s_q.mb_start;

  ////////////////////////////////////////////////////////////////////////////
  AST_HDR_COMPL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid |-> (o_block[0] != o_block[1]))
    else $error("header bits not complementary");
  AST_MULTIBLOCK_END_PILOT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid && o_mb_start |-> s_q.stream[31:27] == 5'h10)
    else $error("stream end pattern wrong");
  AST_EMB_BIT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid |-> s_q.stream[22] == 1'b1 || s_q.stream == '0)
    else $error("extended multiblock end flag clear");
  AST_CMD_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid |-> (s_q.stream & 32'h07170000) == '0)
    else $error("command bits not zero");
  AST_ONES: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid && s_q.stream != '0 |-> (s_q.stream & 32'h00a88888) == 32'h00a88888)
    else $error("fixed ones missing");
  AST_SYSREF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sysref |=> s_q.blk_idx == 5'h0 && o_ext_multiblock_timing_clock)
    else $error("sysref did not realign");
  AST_CRC_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $past(s_q.blk_idx) == 5'h1f && s_q.blk_idx == 5'h0 |-> s_q.crc == '0)
    else $error("crc not cleared at multiblock end");
  AST_HDR_MAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid && $changed(o_block) && !$past(i_sysref)
      |-> o_block[1] == s_q.stream[5'(s_q.blk_idx - 5'h1)])
    else $error("header does not carry stream bit");
  AST_BLK_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_blk_valid && !i_blk_ready |=> o_blk_valid && $stable(o_block))
    else $error("offered block changed before acceptance");
endmodule
`default_nettype wire

// ===== verilog/lbf_pkg.sv
// package: constants for the 64b/66b block framer with crc-12 sync header stream
`default_nettype none
package lbf_pkg;
  localparam int OCTETS_PER_BLOCK = 8;
  localparam int PAYLOAD_W = 64;
  localparam int BLOCK_W = 66;
  localparam int BLOCKS_PER_MB = 32;
  localparam int MB_PER_EMB = 1;
  localparam int CRC_W = 12;
  localparam logic [11:0] CRC_POLY = 12'h987;
  localparam logic [1:0] HDR_ONE = 2'h2;   // line bit0=0, bit1=1 reads as 01
  localparam logic [1:0] HDR_ZERO = 2'h1;  // line bit0=1, bit1=0 reads as 10
  localparam int EMB_END_BIT = 22;
  localparam logic [31:0] FIXED_ONES = 32'h80a88888;
  localparam int FIFO_DEPTH = 4;
endpackage
`default_nettype wire
